// >>> core/configurable_digital_inputs.sv
// Function
// - eight onboard inputs, active when grounded, inactive when floating high.
// - unused analogue measurement inputs may be configured as digital inputs.
// - up to 32 expansion inputs from two CAN modules, treated like local ones.
// - sixteen virtual inputs from logic, handled like physical inputs except that they have no polarity bit.
// - AND-type virtual input active only while every listed condition is true.
// - per-input polarity bit; set means active while open, grounded means inactive.
// - polarity grouped in four settings: onboard, analogue, two expansion halves.
// - all polarity bits zero after reset.
// - each input has function, delay and message settings.
// - delay and message only applied by functions that use them.
// - function leading digit 3 reports states, 4 raises alarms.
// - all inputs share one handling path for function, delay, message; polarity applies to physical inputs only.
// - impulse functions such as fault reset act on the rising logical edge.
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`include "dig_in_defs.svh"
`default_nettype none
module configurable_digital_inputs #(
  parameter int N_ANA     = 4,
  parameter int TICK_CYC  = (`CLK_HZ / 1000) * `DELAY_UNIT_MS
) (
  input  wire  logic                    clk_i,
  input  wire  logic                    rst_i,
  input  wire  dig_in_pkg::wb_req_s     wb_req_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  input  wire  logic [7:0]              onboard_switch_inputs_i,
  input  wire  logic [N_ANA-1:0]        analogue_measure_inputs_i,
  input  wire  logic [31:0]             exp_inputs_i,
  input  wire  logic [1:0]              exp_online_i,
  input  wire  logic [31:0]             cond_i,
  output logic [8+N_ANA+32+16-1:0]      state_active_o,
  output logic [8+N_ANA+32+16-1:0]      alarm_active_o,
  output logic                          alarm_evt_o,
  output dig_in_pkg::alarm_evt_s        alarm_info_o,
  output logic                          fault_reset_command_o,
  output logic [8+N_ANA+32+16-1:0]      impulse_o,
  output logic                          irq_o
);
  import dig_in_pkg::*;

  // ----------------------------------------------------------------
  // input index map
  // ----------------------------------------------------------------
  // indices run onboard first, then analogue, then expansion, then virtual
  localparam int B_ANA = 8;
  localparam int B_EXP = B_ANA + N_ANA;
  localparam int B_VIR = B_EXP + 32;
  localparam int N_IN  = B_VIR + 16;

  // class helpers on the leading digit
  function automatic logic uses_delay(input func_t f);
    uses_delay = (f[15:12] == `CLASS_STATE) || (f[15:12] == `CLASS_ALARM);
  endfunction

  function automatic logic is_class(input func_t f, input logic [3:0] c);
    is_class = (f[15:12] == c);
  endfunction

  // lowest set bit index of a vector of inputs
  function automatic idx_t first_set(input logic [N_IN-1:0] v);
    first_set = '0;
    for (int k = N_IN - 1; k >= 0; k--) begin
      if (v[k]) begin
        first_set = idx_t'(k);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [8+N_ANA-1:0] sync1_ff;
  logic [8+N_ANA-1:0] sync2_ff;

  // two flops on every onboard and analogue pin before any logic looks at it
  // reset to the floating level so no false edge follows reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= '1;
      sync2_ff <= '1;
    end else begin
      sync1_ff <= {analogue_measure_inputs_i, onboard_switch_inputs_i};
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]        pol_onboard_ff;
  logic [N_ANA-1:0]  pol_ana_ff;
  logic [15:0]       pol_exp_lo_ff;
  logic [15:0]       pol_exp_hi_ff;
  logic [N_ANA-1:0]  ana_dig_en_ff;
  logic [2:0]        int_status_ff;
  logic [2:0]        int_mask_ff;
  logic [15:0]       virt_and_ff;
  logic [31:0]       vmask_mem [16];
  input_cfg_s        cfg_mem [N_IN];
  logic              ack_ff;
  logic [31:0]       rdata_ff;

  wire        req      = wb_req_i.cyc & wb_req_i.stb & ~ack_ff;
  // a write lands at the edge that shows ack to the master, while the
  // request still stands, so there is exactly one write per acknowledge
  wire        wr       = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack_ff;
  wire [11:0] adr      = {wb_req_i.adr[11:2], 2'b00};
  wire [31:0] wmask    = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                          {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  wire [31:0] wdat     = wb_req_i.dat & wmask;

  // table decode: slot index and word inside the slot
  wire        in_cfg   = (adr >= `OFS_CFG_BASE) && (adr < `OFS_CFG_BASE + 12'(N_IN * 16));
  wire [11:0] cfg_rel  = adr - `OFS_CFG_BASE;
  wire [5:0]  cfg_idx  = cfg_rel[9:4];
  wire [1:0]  cfg_word = cfg_rel[3:2];
  wire        in_vm    = (adr >= `OFS_VMASK_BASE) && (adr < `OFS_VMASK_BASE + 12'h040);
  wire [3:0]  vm_idx   = adr[5:2];

  // ----------------------------------------------------------------
  // logical state: polarity, analogue enable, virtual logic
  // ----------------------------------------------------------------
  logic [N_IN-1:0]  logic_state;
  logic [15:0]      virt_state;
  wire  [31:0]      pol_exp   = {pol_exp_hi_ff, pol_exp_lo_ff};
  wire  [31:0]      exp_raw   = exp_inputs_i & {{16{exp_online_i[1]}}, {16{exp_online_i[0]}}};

  // virtual inputs: AND needs all listed conditions, OR needs any
  // an AND input with an empty list stays inactive rather than always on
  always_comb begin
    for (int v = 0; v < 16; v++) begin
      if (virt_and_ff[v]) begin
        virt_state[v] = (vmask_mem[v] != '0) && ((cond_i & vmask_mem[v]) == vmask_mem[v]);
      end else begin
        virt_state[v] = (cond_i & vmask_mem[v]) != '0;
      end
    end
  end

  // a grounded pin reads low: active unless the polarity bit inverts it
  assign logic_state[7:0]         = ~sync2_ff[7:0] ^ pol_onboard_ff;
  assign logic_state[B_EXP-1:B_ANA] = (~sync2_ff[8+N_ANA-1:8] ^ pol_ana_ff) & ana_dig_en_ff;
  assign logic_state[B_VIR-1:B_EXP] = exp_raw ^ pol_exp;
  assign logic_state[N_IN-1:B_VIR]  = virt_state;

  // ----------------------------------------------------------------
  // delay tick prescaler
  // ----------------------------------------------------------------
  // one shared prescaler keeps every delay on the same time base
  logic [31:0] pre_ff;
  wire         tick = (pre_ff == 32'(TICK_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // common per-input path
  // ----------------------------------------------------------------
  logic [N_IN-1:0] qual_ff;
  logic [N_IN-1:0] prev_ff;
  logic [N_IN-1:0] rise;
  logic [N_IN-1:0] alarm_rise;
  logic [N_IN-1:0] reset_rise;
  logic [N_IN-1:0] state_mask;
  logic [N_IN-1:0] impulse_mask;
  logic [N_IN-1:0] alarm_mask;

  for (genvar i = 0; i < N_IN; i++) begin : g_in
    delay_t cnt_ff;
    wire    use_dly = uses_delay(cfg_mem[i].func);
    wire    unused  = (cfg_mem[i].func == `RST_FUNC);

    // every input, physical or virtual, runs through this same qualifier
    // any drop restarts the count, so a bounce never shortens the delay
    // the tick phase runs free: n units last between n-1 and n units
    always_ff @(posedge clk_i) begin
      if (rst_i || !logic_state[i] || unused) begin
        cnt_ff     <= '0;
        qual_ff[i] <= 1'b0;
      end else if (!use_dly || cnt_ff >= cfg_mem[i].delay) begin
        qual_ff[i] <= 1'b1;
      end else if (tick) begin
        cnt_ff <= cnt_ff + 16'h1;
      end
    end

    assign state_mask[i]   = is_class(cfg_mem[i].func, `CLASS_STATE);
    assign alarm_mask[i]   = is_class(cfg_mem[i].func, `CLASS_ALARM);
    assign impulse_mask[i] = is_class(cfg_mem[i].func, `CLASS_IMPULSE);
    assign reset_rise[i]   = rise[i] && (cfg_mem[i].func == `FUNC_FAULT_RESET);
  end

  assign rise       = qual_ff & ~prev_ff;
  assign alarm_rise = rise & alarm_mask;

  wire   idx_t first_alarm = first_set(alarm_rise);
  wire   state_chg         = |((qual_ff ^ prev_ff) & state_mask);

  // edge history and event outputs
  // alarms rising together give one event naming the lowest index
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff               <= '0;
      impulse_o             <= '0;
      fault_reset_command_o <= 1'b0;
      alarm_evt_o           <= 1'b0;
      alarm_info_o          <= '0;
    end else begin
      prev_ff               <= qual_ff;
      impulse_o             <= rise & impulse_mask;
      fault_reset_command_o <= |reset_rise;
      alarm_evt_o           <= |alarm_rise;
      if (|alarm_rise) begin
        // message used only by alarm functions
        alarm_info_o <= '{idx: first_alarm, func: cfg_mem[first_alarm].func,
                          msg: cfg_mem[first_alarm].msg};
      end
    end
  end

  assign state_active_o = qual_ff & state_mask;
  assign alarm_active_o = qual_ff & alarm_mask;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  wire [2:0] irq_set = {state_chg, |reset_rise, |alarm_rise};
  wire [2:0] irq_clr = (wr && adr == `OFS_INT_STATUS) ? wdat[2:0] : 3'h0;

  // sticky bits, a new event wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_status_ff <= '0;
    end else begin
      int_status_ff <= (int_status_ff & ~irq_clr) | irq_set;
    end
  end

  // plain level: software clears the cause before the line drops
  assign irq_o = |(int_status_ff & int_mask_ff);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pol_onboard_ff <= 8'(`RST_POLARITY);
      pol_ana_ff     <= '0;
      pol_exp_lo_ff  <= `RST_POLARITY;
      pol_exp_hi_ff  <= `RST_POLARITY;
      ana_dig_en_ff  <= '0;
      int_mask_ff    <= '0;
      virt_and_ff    <= '0;
      for (int k = 0; k < 16; k++) begin
        vmask_mem[k] <= `RST_ZERO32;
      end
      for (int k = 0; k < N_IN; k++) begin
        cfg_mem[k] <= '0;
      end
    end else if (wr) begin
      // byte lanes merge, so a narrow store keeps the other bytes
      case (adr)
        `OFS_POL_ONBOARD:  pol_onboard_ff <= wdat[7:0] | (pol_onboard_ff & ~wmask[7:0]);
        `OFS_POL_ANALOGUE: pol_ana_ff     <= wdat[N_ANA-1:0] | (pol_ana_ff & ~wmask[N_ANA-1:0]);
        `OFS_POL_EXP_LO:   pol_exp_lo_ff  <= wdat[15:0] | (pol_exp_lo_ff & ~wmask[15:0]);
        `OFS_POL_EXP_HI:   pol_exp_hi_ff  <= wdat[15:0] | (pol_exp_hi_ff & ~wmask[15:0]);
        `OFS_ANA_DIG_EN:   ana_dig_en_ff  <= wdat[N_ANA-1:0] | (ana_dig_en_ff & ~wmask[N_ANA-1:0]);
        `OFS_INT_MASK:     int_mask_ff    <= wdat[2:0] | (int_mask_ff & ~wmask[2:0]);
        `OFS_VIRT_AND:     virt_and_ff    <= wdat[15:0] | (virt_and_ff & ~wmask[15:0]);
        default: begin
          if (in_vm) begin
            vmask_mem[vm_idx] <= wdat | (vmask_mem[vm_idx] & ~wmask);
          end else if (in_cfg) begin
            // per-input settings
            case (cfg_word)
              `CFG_WORD_FUNC:  cfg_mem[cfg_idx].func  <= wdat[15:0] | (cfg_mem[cfg_idx].func & ~wmask[15:0]);
              `CFG_WORD_DELAY: cfg_mem[cfg_idx].delay <= wdat[15:0] | (cfg_mem[cfg_idx].delay & ~wmask[15:0]);
              `CFG_WORD_MSG:   cfg_mem[cfg_idx].msg   <= wdat[7:0] | (cfg_mem[cfg_idx].msg & ~wmask[7:0]);
              default: ;
            endcase
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register reads and acknowledge
  // ----------------------------------------------------------------
  logic [31:0]     rmux;
  logic [63:0]     state_all;
  assign state_all = 64'(qual_ff);

  // read selection, unmapped reads return zero
  // the live state words are read-only; writes to them are acked and dropped
  always_comb begin
    rmux = '0;
    case (adr)
      `OFS_POL_ONBOARD:  rmux = 32'(pol_onboard_ff);
      `OFS_POL_ANALOGUE: rmux = 32'(pol_ana_ff);
      `OFS_POL_EXP_LO:   rmux = 32'(pol_exp_lo_ff);
      `OFS_POL_EXP_HI:   rmux = 32'(pol_exp_hi_ff);
      `OFS_ANA_DIG_EN:   rmux = 32'(ana_dig_en_ff);
      `OFS_INT_STATUS:   rmux = 32'(int_status_ff);
      `OFS_INT_MASK:     rmux = 32'(int_mask_ff);
      `OFS_STATE_LO:     rmux = state_all[31:0];
      `OFS_STATE_HI:     rmux = state_all[63:32];
      `OFS_VIRT_AND:     rmux = 32'(virt_and_ff);
      default: begin
        if (in_vm) begin
          rmux = vmask_mem[vm_idx];
        end else if (in_cfg) begin
          case (cfg_word)
            `CFG_WORD_FUNC:  rmux = 32'(cfg_mem[cfg_idx].func);
            `CFG_WORD_DELAY: rmux = 32'(cfg_mem[cfg_idx].delay);
            `CFG_WORD_MSG:   rmux = 32'(cfg_mem[cfg_idx].msg);
            default:         rmux = '0;
          endcase
        end
      end
    endcase
  end

  // one wait state: ack the cycle after the request, drop it next
  // read data is latched with ack so it stands while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff   <= req;
      rdata_ff <= req ? rmux : rdata_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

endmodule
`default_nettype wire

// >>> core/dig_in_defs.svh
`ifndef DIG_IN_DEFS_SVH
`define DIG_IN_DEFS_SVH

// register byte offsets
`define OFS_POL_ONBOARD  12'h000
`define OFS_POL_ANALOGUE 12'h004
`define OFS_POL_EXP_LO   12'h008
`define OFS_POL_EXP_HI   12'h00c
`define OFS_ANA_DIG_EN   12'h010
`define OFS_INT_STATUS   12'h014
`define OFS_INT_MASK     12'h018
`define OFS_STATE_LO     12'h01c
`define OFS_STATE_HI     12'h020
`define OFS_VIRT_AND     12'h024
`define OFS_VMASK_BASE   12'h200
`define OFS_CFG_BASE     12'h400

// per-input table entry: word offsets inside a 16-byte slot
`define CFG_WORD_FUNC    2'h0
`define CFG_WORD_DELAY   2'h1
`define CFG_WORD_MSG     2'h2

// reset values
`define RST_POLARITY     16'h0000
`define RST_FUNC         16'h0000
`define RST_ZERO32       32'h0000_0000

// function code classes (leading digit)
`define CLASS_IMPULSE    4'h2
`define CLASS_STATE      4'h3
`define CLASS_ALARM      4'h4
`define FUNC_FAULT_RESET 16'h2001

// interrupt status bits
`define IRQ_ALARM        0
`define IRQ_FAULT_RESET  1
`define IRQ_STATE_CHG    2

// timing: delay unit and clock
`define DELAY_UNIT_MS    100
`define CLK_HZ           40000000

`endif

// >>> core/dig_in_pkg.sv
`default_nettype none
package dig_in_pkg;
  typedef logic [15:0] func_t;
  typedef logic [15:0] delay_t;
  typedef logic [7:0]  msg_t;
  typedef logic [5:0]  idx_t;

  // per-input configuration
  typedef struct packed {
    func_t  func;
    delay_t delay;
    msg_t   msg;
  } input_cfg_s;

  // alarm event reported to the alarm logic
  typedef struct packed {
    idx_t   idx;
    func_t  func;
    msg_t   msg;
  } alarm_evt_s;

  // classic wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } wb_req_s;
endpackage
`default_nettype wire

// >>> tb/configurable_digital_inputs_assertions.sv
`default_nettype none
module configurable_digital_inputs_assertions #(
  parameter int N_ANA = 4
) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire dig_in_pkg::wb_req_s    wb_req_i,
  input wire logic                   wb_ack_o,
  input wire logic [N_ANA+55:0]      state_active_o,
  input wire logic [N_ANA+55:0]      alarm_active_o,
  input wire logic                   alarm_evt_o,
  input wire dig_in_pkg::alarm_evt_s alarm_info_o,
  input wire logic                   fault_reset_command_o,
  input wire logic [N_ANA+55:0]      impulse_o,
  input wire logic                   irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dig_in_pkg::*;
  // ----
  // port checks
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answers: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_reset_quiet: assert property ($past(rst_i) |-> !irq_o && !alarm_evt_o && state_active_o == '0
    && alarm_active_o == '0) else $error("outputs active after reset");
  a_class_split: assert property ((state_active_o & alarm_active_o) == '0)
    else $error("input both state and alarm");
  a_evt_cause: assert property (alarm_evt_o |->
    ($past(alarm_active_o) & ~$past(alarm_active_o, 2)) != '0) else $error("alarm event without rise");
  a_info_holds: assert property (!alarm_evt_o && !$past(rst_i) |-> $stable(alarm_info_o))
    else $error("alarm info changed without event");
  a_fault_single: assert property (fault_reset_command_o |=> !fault_reset_command_o)
    else $error("fault reset longer than one cycle");
  a_fault_impulse: assert property (fault_reset_command_o |-> impulse_o != '0)
    else $error("fault reset without impulse");
  a_impulse_single: assert property ((impulse_o & $past(impulse_o)) == '0)
    else $error("impulse longer than one cycle");
endmodule
bind configurable_digital_inputs configurable_digital_inputs_assertions #(.N_ANA(N_ANA)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o),
  .state_active_o(state_active_o), .alarm_active_o(alarm_active_o), .alarm_evt_o(alarm_evt_o),
  .alarm_info_o(alarm_info_o), .fault_reset_command_o(fault_reset_command_o),
  .impulse_o(impulse_o), .irq_o(irq_o));
`default_nettype wire

// >>> tb/configurable_digital_inputs_tb_top.sv
`include "dig_in_defs.svh"
`default_nettype none
module configurable_digital_inputs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dig_in_pkg::*;
  logic        clk_i, rst_i, ack, irq, evt, frc;
  wb_req_s     req;
  alarm_evt_s  info;
  logic [31:0] dat, rd, ex, exp_p, cnd;
  logic [59:0] st, al, imp;
  logic [7:0]  sw, swp;
  logic [3:0]  ana, anap;
  logic [1:0]  on, onp;
  int          miscompares, n_compared, n_fr, n_evt, n_imp;
  // ----
  // harness
  // ----
  configurable_digital_inputs #(.N_ANA(4), .TICK_CYC(10)) u_configurable_digital_inputs (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack),
    .onboard_switch_inputs_i(swp), .analogue_measure_inputs_i(anap), .exp_inputs_i(exp_p),
    .exp_online_i(onp), .cond_i(cnd), .state_active_o(st), .alarm_active_o(al),
    .alarm_evt_o(evt), .alarm_info_o(info), .fault_reset_command_o(frc), .impulse_o(imp), .irq_o(irq));
  dig_in_field_model u_dig_in_field_model (.sw_closed_i(sw), .ana_closed_i(ana), .ex_closed_i(ex),
    .online_i(on), .sw_pin_o(swp), .ana_pin_o(anap), .ex_pin_o(exp_p), .online_o(onp));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // count one-cycle pulses
  always @(posedge clk_i) begin
    if (frc === 1'b1) n_fr++;
    if (evt === 1'b1) n_evt++;
    if (imp[2] === 1'b1) n_imp++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    // only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat;
    req <= '0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic cfg(input int i, input logic [15:0] f, input logic [15:0] dl, input logic [7:0] m);
    logic [11:0] b;
    b = `OFS_CFG_BASE + 12'(i * 16);
    wr(b + {8'h0, `CFG_WORD_FUNC, 2'b0}, {16'h0, f});
    wr(b + {8'h0, `CFG_WORD_DELAY, 2'b0}, {16'h0, dl});
    wr(b + {8'h0, `CFG_WORD_MSG, 2'b0}, {24'h0, m});
  endtask
  task automatic set_in(input int k, input logic v);
    case (k)
      0: sw[0] <= v;
      1: ana[0] <= v;
      2: ex[0] <= v;
      default: ex[16] <= v;
    endcase
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_polarity();
    logic [11:0] pol [4];
    int idx [4];
    pol = '{`OFS_POL_ONBOARD, `OFS_POL_ANALOGUE, `OFS_POL_EXP_LO, `OFS_POL_EXP_HI};
    idx = '{0, 8, 12, 28};
    wr(`OFS_ANA_DIG_EN, 32'h1);
    for (int k = 0; k < 4; k++) begin
      rdchk(pol[k], 32'h0);
      cfg(idx[k], 16'h3001, 16'h0, 8'h0);
      set_in(k, 1'b1);
      wt(6);
      chkb(st[idx[k]], 1'b1);
      rdchk(`OFS_STATE_LO, 32'h1 << idx[k]);
      wr(pol[k], 32'h1);
      wt(6);
      chkb(st[idx[k]], 1'b0);
      set_in(k, 1'b0);
      wt(6);
      chkb(st[idx[k]], 1'b1);
      wr(pol[k], 32'h0);
      cfg(idx[k], 16'h0, 16'h0, 8'h0);
    end
    rdchk(12'h100, 32'h0);
    $display("polarity test done");
  endtask
  task automatic t_offline();
    cfg(12, 16'h3001, 16'h0, 8'h0);
    on <= 2'b10;
    ex[0] <= 1'b1;
    wt(6);
    chkb(st[12], 1'b0);
    on <= 2'b11;
    wt(6);
    chkb(st[12], 1'b1);
    ex[0] <= 1'b0;
    cfg(12, 16'h0, 16'h0, 8'h0);
    $display("offline test done");
  endtask
  task automatic t_virtual();
    cfg(44, 16'h3001, 16'h0, 8'h0);
    wr(`OFS_VMASK_BASE, 32'h3);
    wr(`OFS_VIRT_AND, 32'h1);
    cnd <= 32'h1;
    wt(6);
    chkb(st[44], 1'b0);
    cnd <= 32'h3;
    wt(6);
    chkb(st[44], 1'b1);
    wr(`OFS_VIRT_AND, 32'h0);
    cnd <= 32'h2;
    wt(6);
    chkb(st[44], 1'b1);
    cnd <= 32'h0;
    cfg(44, 16'h0, 16'h0, 8'h0);
    $display("virtual test done");
  endtask
  task automatic t_alarm();
    int e0;
    e0 = n_evt;
    wr(`OFS_INT_STATUS, 32'h7);
    wr(`OFS_INT_MASK, 32'h1);
    cfg(1, 16'h4001, 16'h0, 8'h5a);
    sw[1] <= 1'b1;
    wt(6);
    chkb(al[1], 1'b1);
    chk(32'(n_evt - e0), 32'h1);
    chk({2'b0, info}, {2'b0, 6'd1, 16'h4001, 8'h5a});
    chkb(irq, 1'b1);
    rdchk(`OFS_INT_STATUS, 32'h1);
    wr(`OFS_INT_MASK, 32'h0);
    wt(1);
    chkb(irq, 1'b0);
    wr(`OFS_INT_MASK, 32'h1);
    wr(`OFS_INT_STATUS, 32'h1);
    wt(1);
    chkb(irq, 1'b0);
    sw[1] <= 1'b0;
    cfg(1, 16'h0, 16'h0, 8'h0);
    $display("alarm test done");
  endtask
  task automatic t_fault();
    int f0;
    int i0;
    f0 = n_fr;
    i0 = n_imp;
    cfg(2, `FUNC_FAULT_RESET, 16'h0, 8'h0);
    sw[2] <= 1'b1;
    wt(12);
    chk(32'(n_fr - f0), 32'h1);
    sw[2] <= 1'b0;
    wt(6);
    sw[2] <= 1'b1;
    wt(6);
    chk(32'(n_fr - f0), 32'h2);
    chk(32'(n_imp - i0), 32'h2);
    rdchk(`OFS_INT_STATUS, 32'h2);
    sw[2] <= 1'b0;
    $display("fault reset test done");
  endtask
  task automatic t_delay();
    cfg(3, 16'h3001, 16'h3, 8'h0);
    sw[3] <= 1'b1;
    wt(15);
    chkb(st[3], 1'b0);
    wt(30);
    chkb(st[3], 1'b1);
    sw[3] <= 1'b0;
    wt(6);
    sw[3] <= 1'b1;
    wt(15);
    chkb(st[3], 1'b0);
    sw[3] <= 1'b0;
    $display("delay test done");
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    req = '0;
    sw = '0;
    ana = '0;
    ex = '0;
    on = 2'b11;
    cnd = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_polarity();
    t_offline();
    t_virtual();
    t_alarm();
    t_fault();
    t_delay();
    finish_test();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire

// >>> tb/dig_in_field_model.sv
`default_nettype none
// field contacts and the two expansion modules on the far side
module dig_in_field_model (
  input  wire logic [7:0]  sw_closed_i,
  input  wire logic [3:0]  ana_closed_i,
  input  wire logic [31:0] ex_closed_i,
  input  wire logic [1:0]  online_i,
  output logic      [7:0]  sw_pin_o,
  output logic      [3:0]  ana_pin_o,
  output logic      [31:0] ex_pin_o,
  output logic      [1:0]  online_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // an open contact floats up to battery, a closed one pulls the pin low
  assign sw_pin_o  = ~sw_closed_i;
  assign ana_pin_o = ~ana_closed_i;
  // an absent module carries no valid data, so show the inverse pattern
  assign ex_pin_o = {online_i[1] ? ex_closed_i[31:16] : ~ex_closed_i[31:16],
                     online_i[0] ? ex_closed_i[15:0] : ~ex_closed_i[15:0]};
  assign online_o = online_i;
endmodule
`default_nettype wire
